// File: rtl/rimp_pkg.sv
package rimp_pkg;

  // ****************************************
  // Processors and posting queue
  // ****************************************
  localparam int          NCPU      = 2;
  localparam int          CPU_W     = 1;
  localparam int          Q_DEPTH   = 4;
  localparam int          QIX_W     = 2;
  localparam logic [2:0]  Q_FULL    = 3'h4;
  localparam logic [2:0]  CPU_QUOTA = 3'h2;

  // ****************************************
  // Mailbox pointer register and mailbox layout
  // ****************************************
  localparam logic [47:0] PTR_IO_ADDR  = 48'h0000_0080_0000;
  localparam int          PTR_LO       = 6;
  localparam int          PTR_HI       = 47;
  localparam int          PTR_W        = 42;
  localparam int          QA_W         = 45;
  localparam logic [5:0]  MB_CMD_OFF   = 6'h00;
  localparam logic [5:0]  MB_ADDR_OFF  = 6'h08;
  localparam logic [5:0]  MB_WDATA_OFF = 6'h10;
  localparam logic [5:0]  MB_RDATA_OFF = 6'h20;
  localparam logic [5:0]  MB_STAT_OFF  = 6'h28;
  localparam int          CMD_LO       = 0;
  localparam int          CMD_W        = 30;
  localparam int          SPECIAL_BIT  = 30;
  localparam int          WRITE_BIT    = 31;
  localparam int          MASK_LO      = 32;
  localparam int          MASK_W       = 8;
  localparam int          HOSE_LO      = 48;
  localparam int          HOSE_W       = 8;
  localparam int          RDATA_W      = 32;
  localparam int          RB_STAT_W    = 8;

  // ****************************************
  // Processor agent registers (APB byte offsets)
  // ****************************************
  localparam logic [7:0]  A_MEM_IDX  = 8'h00;
  localparam logic [7:0]  A_MEM_LO   = 8'h04;
  localparam logic [7:0]  A_MEM_HI   = 8'h08;
  localparam logic [7:0]  A_PTR_LO   = 8'h0c;
  localparam logic [7:0]  A_PTR_HI   = 8'h10;
  localparam logic [7:0]  A_POST     = 8'h14;
  localparam logic [7:0]  A_STATUS   = 8'h18;
  localparam logic [7:0]  A_RETRIES  = 8'h1c;
  localparam int          HMEM_QW    = 32;
  localparam int          HMEM_IX_W  = 5;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_CMD   = 7'h02,
    ST_ADDR  = 7'h04,
    ST_DATA  = 7'h08,
    ST_RMT   = 7'h10,
    ST_RDATA = 7'h20,
    ST_STAT  = 7'h40
  } rimp_eng_t;

  // Quadword address of one mailbox field
  function automatic logic [QA_W-1:0] rimp_qw_addr(input logic [PTR_W-1:0] ptr,
                                                   input logic [5:0]       off);
    return {ptr, off[5:3]};
  endfunction

endpackage

// File: rtl/rimp_link_if.sv
`timescale 1ns/1ns
interface rimp_link_if;
  import rimp_pkg::*;

  logic             post_req;
  logic [CPU_W-1:0] post_cpu;
  logic [47:0]      post_addr;
  logic [63:0]      post_data;
  logic             post_ack;
  logic [CPU_W-1:0] post_ack_cpu;
  logic             post_ok;
  logic             mem_req;
  logic             mem_we;
  logic [QA_W-1:0]  mem_addr;
  logic [63:0]      mem_wdata;
  logic [63:0]      mem_rdata;
  logic             mem_ack;

  modport bridge (
    input  post_req, post_cpu, post_addr, post_data, mem_rdata, mem_ack,
    output post_ack, post_ack_cpu, post_ok, mem_req, mem_we, mem_addr, mem_wdata
  );

  modport cpu (
    output post_req, post_cpu, post_addr, post_data, mem_rdata, mem_ack,
    input  post_ack, post_ack_cpu, post_ok, mem_req, mem_we, mem_addr, mem_wdata
  );
endinterface

// File: rtl/rimp_bridge.sv
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ns
// Notes on behaviour
// RULE1: remote access starts only from pointer write
// RULE2: pointer in bits 47:6, rest zero
// RULE3: mailbox is 64 bytes, 64-byte aligned
// RULE4: pointer written only by store-conditional quadword
// RULE5: accepted post reports success to writer
// RULE6: full resources refuse; processor retries
// RULE7: outcome reaches only the writing processor
// RULE8: one pointer register per remote bus
// RULE9: pointer register decoded in local I/O space
// RULE10: same address for every processor
// RULE11: queue invisible beyond accept or refuse
// RULE12: per-processor share keeps posting fair
// RULE13: no processor can lock others out
// RULE14: mailbox progress independent of DMA/interrupt load
// RULE15: hose select covers 256 hoses
// RULE16: writes take data; reads return data
// RULE17: decode command quadword fields
// RULE18: address at 8, wdata 16, rdata 32
// RULE19: completion quadword at 40, done, error
// RULE20: one bus executes in posting order
// RULE21: fetch address is pointer with six zeros
module rimp_bridge (
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  rimp_link_if.bridge                         lk,
  output logic                                rb_req,
  output logic [rimp_pkg::HOSE_W-1:0]         rb_hose,
  output logic [rimp_pkg::CMD_W-1:0]          rb_cmd,
  output logic                                rb_special,
  output logic                                rb_write,
  output logic [rimp_pkg::MASK_W-1:0]         rb_mask,
  output logic [63:0]                         rb_addr,
  output logic [63:0]                         rb_wdata,
  input  wire logic                           rb_ack,
  input  wire logic                           rb_err,
  input  wire logic [rimp_pkg::RDATA_W-1:0]   rb_rdata,
  input  wire logic [rimp_pkg::RB_STAT_W-1:0] rb_status
);
  import rimp_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [Q_DEPTH-1:0][PTR_W-1:0] q_ptr;
    logic [Q_DEPTH-1:0][CPU_W-1:0] q_cpu;
    logic [QIX_W-1:0]              wr_ix;
    logic [QIX_W-1:0]              rd_ix;
    logic [2:0]                    count;
    logic [NCPU-1:0][2:0]          share;
    logic                          ack;
    logic                          ok;
    logic [CPU_W-1:0]              ack_cpu;
    rimp_eng_t                     st;
    logic [CPU_W-1:0]              cur_cpu;
    logic [PTR_W-1:0]              ptr;
    logic [63:0]                   cmd;
    logic [63:0]                   raddr;
    logic [63:0]                   wdata;
    logic                          mem_req;
    logic                          mem_we;
    logic [QA_W-1:0]               mem_addr;
    logic [63:0]                   mem_wdata;
    logic                          rb_req;
  } rimp_br_t;

  rimp_br_t s_q;
  rimp_br_t s_d;

  logic take;
  logic hit;
  logic room;
  logic push;
  logic pop;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.ack = 1'b0;
    pop = 1'b0;
    // One decision per request; the cycle after an answer is skipped
    take = lk.post_req && !s_q.ack;
    // Decode ignores which processor writes
    hit = (lk.post_addr == PTR_IO_ADDR); // RULE9 RULE10 RULE8 RULE4
    // A processor may hold only its share, so the others always find room
    room = (s_q.count < Q_FULL) && (s_q.share[lk.post_cpu] < CPU_QUOTA); // RULE12 RULE13
    push = take && hit && room; // RULE1 RULE11
    if (take) begin
      s_d.ack = 1'b1;
      s_d.ok = push; // RULE5 RULE6
      s_d.ack_cpu = lk.post_cpu; // RULE7
    end
    if (push) begin
      s_d.q_ptr[s_q.wr_ix] = lk.post_data[PTR_HI:PTR_LO]; // RULE2 RULE21
      s_d.q_cpu[s_q.wr_ix] = lk.post_cpu;
      s_d.wr_ix = s_q.wr_ix + 1'b1;
    end

    // Mailbox engine; it waits on nothing but its own memory and remote ports
    unique case (s_q.st) // RULE14
      ST_IDLE: begin
        if (s_q.count != 3'h0) begin
          // Single FIFO keeps posting order for the bus behind this pointer
          s_d.ptr = s_q.q_ptr[s_q.rd_ix]; // RULE20
          s_d.cur_cpu = s_q.q_cpu[s_q.rd_ix];
          s_d.mem_req = 1'b1;
          s_d.mem_we = 1'b0;
          s_d.mem_addr = rimp_qw_addr(s_q.q_ptr[s_q.rd_ix], MB_CMD_OFF); // RULE21 RULE3
          s_d.st = ST_CMD;
        end
      end
      ST_CMD: begin
        if (lk.mem_ack) begin
          s_d.cmd = lk.mem_rdata; // RULE17
          s_d.mem_addr = rimp_qw_addr(s_q.ptr, MB_ADDR_OFF); // RULE18
          s_d.st = ST_ADDR;
        end
      end
      ST_ADDR: begin
        if (lk.mem_ack) begin
          s_d.raddr = lk.mem_rdata; // RULE18
          if (s_q.cmd[WRITE_BIT]) begin
            s_d.mem_addr = rimp_qw_addr(s_q.ptr, MB_WDATA_OFF); // RULE16
            s_d.st = ST_DATA;
          end else begin
            s_d.mem_req = 1'b0;
            s_d.rb_req = 1'b1;
            s_d.st = ST_RMT;
          end
        end
      end
      ST_DATA: begin
        if (lk.mem_ack) begin
          s_d.wdata = lk.mem_rdata; // RULE18
          s_d.mem_req = 1'b0;
          s_d.rb_req = 1'b1;
          s_d.st = ST_RMT;
        end
      end
      ST_RMT: begin
        if (rb_ack) begin
          s_d.rb_req = 1'b0;
          s_d.mem_req = 1'b1;
          s_d.mem_we = 1'b1;
          // Completion word also prepared here; kept in mem_wdata path below
          s_d.wdata = {{(64 - RB_STAT_W - 2){1'b0}}, rb_status, rb_err, 1'b1}; // RULE19
          if (s_q.cmd[WRITE_BIT]) begin
            s_d.mem_addr = rimp_qw_addr(s_q.ptr, MB_STAT_OFF); // RULE19
            s_d.mem_wdata = {{(64 - RB_STAT_W - 2){1'b0}}, rb_status, rb_err, 1'b1};
            s_d.st = ST_STAT;
          end else begin
            s_d.mem_addr = rimp_qw_addr(s_q.ptr, MB_RDATA_OFF); // RULE18 RULE16
            s_d.mem_wdata = {{(64 - RDATA_W){1'b0}}, rb_rdata};
            s_d.st = ST_RDATA;
          end
        end
      end
      ST_RDATA: begin
        // Data lands before done so done always marks valid fields
        if (lk.mem_ack) begin
          s_d.mem_addr = rimp_qw_addr(s_q.ptr, MB_STAT_OFF); // RULE19
          s_d.mem_wdata = s_q.wdata;
          s_d.st = ST_STAT;
        end
      end
      ST_STAT: begin
        if (lk.mem_ack) begin
          s_d.mem_req = 1'b0;
          s_d.mem_we = 1'b0;
          pop = 1'b1;
          s_d.rd_ix = s_q.rd_ix + 1'b1;
          s_d.st = ST_IDLE;
        end
      end
      default: begin
        s_d.st = ST_IDLE;
        s_d.mem_req = 1'b0;
        s_d.rb_req = 1'b0;
      end
    endcase

    // Occupancy and per-processor shares
    s_d.count = 3'(s_q.count + {2'h0, push} - {2'h0, pop}); // RULE11
    for (int c = 0; c < NCPU; c++) begin
      s_d.share[c] = 3'(s_q.share[c]
                     + {2'h0, push && (lk.post_cpu == CPU_W'(c))}
                     - {2'h0, pop && (s_q.cur_cpu == CPU_W'(c))}); // RULE12
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign lk.post_ack     = s_q.ack;
  assign lk.post_ok      = s_q.ok;
  assign lk.post_ack_cpu = s_q.ack_cpu;
  assign lk.mem_req      = s_q.mem_req;
  assign lk.mem_we       = s_q.mem_we;
  assign lk.mem_addr     = s_q.mem_addr;
  assign lk.mem_wdata    = s_q.mem_wdata;
  assign rb_req          = s_q.rb_req;
  assign rb_hose         = s_q.cmd[HOSE_LO +: HOSE_W]; // RULE15 RULE17
  assign rb_cmd          = s_q.cmd[CMD_LO +: CMD_W];
  assign rb_special      = s_q.cmd[SPECIAL_BIT];
  assign rb_write        = s_q.cmd[WRITE_BIT];
  assign rb_mask         = s_q.cmd[MASK_LO +: MASK_W];
  assign rb_addr         = s_q.raddr;
  assign rb_wdata        = s_q.wdata;

endmodule

// File: rtl/rimp_cpu_agent.sv
`timescale 1ns/1ns
module rimp_cpu_agent (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  rimp_link_if.cpu         lk
);
  import rimp_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [HMEM_QW-1:0][63:0] mem;
    logic [HMEM_IX_W-1:0]     idx;
    logic [63:0]              ptr;
    logic [CPU_W-1:0]         cpu;
    logic                     req;
    logic                     last_ok;
    logic [15:0]              retries;
    logic                     mem_ack;
    logic [63:0]              mem_rdata;
    logic [31:0]              prdata;
  } rimp_cpu_t;

  rimp_cpu_t s_q;
  rimp_cpu_t s_d;

  logic                 wr;
  logic                 mem_apb;
  logic                 mapped;
  logic [HMEM_IX_W-1:0] mix;

  function automatic logic is_mapped(input logic [31:0] a);
    return a[31:8] == 24'h0 && a[1:0] == 2'h0 && a[7:0] <= A_RETRIES;
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.mem_ack = 1'b0;
    mapped = is_mapped(paddr);
    wr = psel && penable && pwrite && mapped;
    mem_apb = wr && (paddr[7:0] == A_MEM_LO || paddr[7:0] == A_MEM_HI);
    mix = lk.mem_addr[HMEM_IX_W-1:0];

    // Read data is captured in the setup cycle, answered in the access cycle
    if (psel && !penable) begin
      unique case (paddr[7:0])
        A_MEM_IDX: s_d.prdata = {27'h0, s_q.idx};
        A_MEM_LO:  s_d.prdata = s_q.mem[s_q.idx][31:0];
        A_MEM_HI:  s_d.prdata = s_q.mem[s_q.idx][63:32];
        A_PTR_LO:  s_d.prdata = s_q.ptr[31:0];
        A_PTR_HI:  s_d.prdata = s_q.ptr[63:32];
        A_STATUS:  s_d.prdata = {30'h0, s_q.last_ok, s_q.req};
        A_RETRIES: s_d.prdata = {16'h0, s_q.retries};
        default:   s_d.prdata = 32'h0;
      endcase
    end

    if (wr) begin
      unique case (paddr[7:0])
        A_MEM_IDX: s_d.idx = pwdata[HMEM_IX_W-1:0];
        A_MEM_LO:  s_d.mem[s_q.idx][31:0] = pwdata;
        A_MEM_HI:  s_d.mem[s_q.idx][63:32] = pwdata;
        A_PTR_LO:  s_d.ptr[31:0] = pwdata;
        A_PTR_HI:  s_d.ptr[63:32] = pwdata;
        A_POST: begin
          // A post in flight is not disturbed; software polls busy first
          if (!s_q.req) begin
            s_d.req = 1'b1;
            s_d.cpu = pwdata[CPU_W-1:0];
            s_d.last_ok = 1'b0;
            s_d.retries = 16'h0;
          end
        end
        default: s_d.retries = s_q.retries;
      endcase
    end

    // Memory port for the bridge; an APB write to the same array goes first
    if (lk.mem_req && !s_q.mem_ack && !mem_apb) begin
      if (lk.mem_we) begin
        s_d.mem[mix] = lk.mem_wdata;
      end else begin
        s_d.mem_rdata = s_q.mem[mix];
      end
      s_d.mem_ack = 1'b1;
    end

    // Refused posts stay raised, so they are retried every other cycle
    if (s_q.req && lk.post_ack && lk.post_ack_cpu == s_q.cpu) begin // RULE7
      if (lk.post_ok) begin // RULE5
        s_d.req = 1'b0;
        s_d.last_ok = 1'b1;
      end else begin
        s_d.retries = 16'(s_q.retries + 16'h1); // RULE6
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata       = s_q.prdata;
  assign pready       = psel && penable;
  assign pslverr      = psel && penable && !mapped;
  assign lk.post_req  = s_q.req; // RULE1 RULE4
  assign lk.post_cpu  = s_q.cpu;
  assign lk.post_addr = PTR_IO_ADDR; // RULE10
  // Must-be-zero bits forced to zero on the way out
  assign lk.post_data = {16'h0, s_q.ptr[PTR_HI:PTR_LO], 6'h0}; // RULE2 RULE3
  assign lk.mem_ack   = s_q.mem_ack;
  assign lk.mem_rdata = s_q.mem_rdata;

endmodule

// File: testbench/rimp_link_monitor.sv
`timescale 1ns/1ns
module rimp_link_monitor (
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       post_req,
  input wire logic [rimp_pkg::CPU_W-1:0] post_cpu,
  input wire logic [47:0]                post_addr,
  input wire logic [63:0]                post_data,
  input wire logic                       post_ack,
  input wire logic [rimp_pkg::CPU_W-1:0] post_ack_cpu,
  input wire logic                       post_ok,
  input wire logic                       mem_req,
  input wire logic                       mem_we,
  input wire logic [rimp_pkg::QA_W-1:0]  mem_addr,
  input wire logic [63:0]                mem_wdata,
  input wire logic                       mem_ack
);
  import rimp_pkg::*;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ****************************************
  // Post link
  // ****************************************
  chk_ack_pulse: assert property (post_ack |=> !post_ack)
    else $error("post answer held longer than one cycle");
  chk_ack_timing: assert property (post_req && !post_ack |=> post_ack)
    else $error("post request not answered on the next cycle");
  chk_ack_owner: assert property (post_ack |-> post_ack_cpu == $past(post_cpu) && $past(post_req))
    else $error("post answer aimed at the wrong processor");
  chk_ptr_zero: assert property (post_req |-> post_data[5:0] == 6'h00 && post_data[63:48] == 16'h0000)
    else $error("pointer must-be-zero bits not zero");
  chk_ptr_addr: assert property (post_req |-> post_addr == PTR_IO_ADDR)
    else $error("pointer write at an unexpected address");

  // ****************************************
  // Memory link
  // ****************************************
  chk_mem_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("memory request changed before its answer");
  chk_fetch_offs: assert property (mem_req && !mem_we |-> mem_addr[2:0] <= 3'h2)
    else $error("mailbox fetch outside the first three quadwords");
  chk_write_offs: assert property (mem_req && mem_we |-> mem_addr[2:0] inside {3'h4, 3'h5})
    else $error("mailbox write outside the result quadwords");
  chk_done_word: assert property (mem_req && mem_we && mem_addr[2:0] == 3'h5 |-> mem_wdata[0] && mem_wdata[63:10] == 54'h0)
    else $error("completion quadword malformed");

  cov_refuse: cover property (post_ack && !post_ok);
  cov_accept_cpu1: cover property (post_ack && post_ok && post_ack_cpu == 1'b1);
  cov_rdata_write: cover property (mem_req && mem_we && mem_addr[2:0] == 3'h4);
endmodule

// File: testbench/remote_io_mailbox_poster_tb.sv
`timescale 1ns/1ns
module remote_io_mailbox_poster_tb;
  import rimp_pkg::*;
  typedef struct packed {
    logic [7:0] hose; logic [29:0] cmd; logic sp; logic wr; logic [7:0] mask;
    logic [63:0] addr; logic [63:0] wdata; logic [1:0] slot;
  } rimp_note_t;
  logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
  logic [31:0]      paddr, pwdata, prdata, r;
  logic             rb_req, rb_special, rb_write, rb_ack, rb_err;
  logic [7:0]       rb_hose, rb_mask, rb_status;
  logic [29:0]      rb_cmd;
  logic [63:0]      rb_addr, rb_wdata;
  logic [31:0]      rb_rdata;
  rimp_note_t       note [4];
  rimp_note_t       exp_q [$];
  logic [31:0]      rsp_rd [4];
  logic [7:0]       rsp_st [4];
  logic             rsp_err [4];
  int               bad_count, total_checks, stall;
  int               seed = 78;

  rimp_link_if lk();
  rimp_cpu_agent i_rimp_cpu_agent (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lk(lk));
  rimp_bridge i_rimp_bridge (.pclk(pclk), .presetn(presetn), .lk(lk), .rb_req(rb_req),
    .rb_hose(rb_hose), .rb_cmd(rb_cmd), .rb_special(rb_special), .rb_write(rb_write),
    .rb_mask(rb_mask), .rb_addr(rb_addr), .rb_wdata(rb_wdata), .rb_ack(rb_ack),
    .rb_err(rb_err), .rb_rdata(rb_rdata), .rb_status(rb_status));
  rimp_link_monitor i_rimp_link_monitor (.pclk(pclk), .presetn(presetn),
    .post_req(lk.post_req), .post_cpu(lk.post_cpu), .post_addr(lk.post_addr),
    .post_data(lk.post_data), .post_ack(lk.post_ack), .post_ack_cpu(lk.post_ack_cpu),
    .post_ok(lk.post_ok), .mem_req(lk.mem_req), .mem_we(lk.mem_we),
    .mem_addr(lk.mem_addr), .mem_wdata(lk.mem_wdata), .mem_ack(lk.mem_ack));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No wait-state count is assumed; only the watchdog ends a stuck access
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wq(input logic [4:0] ix, input logic [63:0] d);
    apb(1'b1, A_MEM_IDX, {27'h0, ix}, r);
    apb(1'b1, A_MEM_LO, d[31:0], r);
    apb(1'b1, A_MEM_HI, d[63:32], r);
  endtask

  task automatic rq(input logic [4:0] ix, output logic [63:0] q);
    apb(1'b1, A_MEM_IDX, {27'h0, ix}, r);
    apb(1'b0, A_MEM_LO, 32'h0, q[31:0]);
    apb(1'b0, A_MEM_HI, 32'h0, q[63:32]);
  endtask

  // Random hose, command and data; completion quadword preset so stale values show
  task automatic mk(input int s, input logic w);
    rimp_note_t   n;
    logic [191:0] rnd;
    rnd = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed),
           $random(seed)};
    n = rnd[$bits(rimp_note_t)-1:0];
    n.wr = w;
    n.slot = 2'(s);
    note[s] = n;
    wq(5'(s * 8), {8'h0, n.hose, 8'h0, n.mask, n.wr, n.sp, n.cmd});
    wq(5'(s * 8 + 1), n.addr);
    wq(5'(s * 8 + 2), n.wdata);
    wq(5'(s * 8 + 5), 64'hffff_ffff_ffff_fffe);
  endtask

  // Junk in must-be-zero bits and in pointer bits above the aliased memory
  task automatic post(input logic cpu, input int s, input logic exp_wait);
    logic [63:0] p;
    p = {$random(seed), $random(seed)};
    p[7:6] = 2'(s);
    exp_q.push_back(note[s]);
    apb(1'b1, A_PTR_LO, p[31:0], r);
    apb(1'b1, A_PTR_HI, p[63:32], r);
    apb(1'b1, A_POST, {31'h0, cpu}, r);
    if (exp_wait) begin
      for (int i = 0; i < 300; i++) begin
        apb(1'b0, A_STATUS, 32'h0, r);
        if (r[0] === 1'b0) break;
      end
      check(r[1:0], 2'b10, "post accepted");
    end
  endtask

  task automatic verify(input int s);
    logic [63:0] q;
    for (int i = 0; i < 300; i++) begin
      rq(5'(s * 8 + 5), q);
      if (q[0] === 1'b1) break;
    end
    check(q, {54'h0, rsp_st[s], rsp_err[s], 1'b1}, "completion word");
    if (!note[s].wr) begin
      rq(5'(s * 8 + 4), q);
      check(q[31:0], rsp_rd[s], "read data");
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ****************************************
  // Clock, remote side and watchdog
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  initial begin
    rimp_note_t n;
    rb_ack = 1'b0; rb_err = 1'b0; rb_rdata = 32'h0; rb_status = 8'h0;
    forever begin
      // Looked at mid-cycle, where the registered request has settled
      @(negedge pclk);
      if (rb_req === 1'b1) begin
        if (exp_q.size() == 0) check(1'b1, 1'b0, "unexpected remote request");
        n = exp_q.pop_front();
        check({rb_hose, rb_cmd, rb_special, rb_write, rb_mask},
              {n.hose, n.cmd, n.sp, n.wr, n.mask}, "remote fields");
        check(rb_addr, n.addr, "remote address");
        if (n.wr) check(rb_wdata, n.wdata, "remote write data");
        repeat (stall) @(posedge pclk);
        rsp_rd[n.slot] = $random(seed);
        rsp_st[n.slot] = 8'($random(seed));
        rsp_err[n.slot] = 1'($random(seed));
        rb_ack <= 1'b1;
        rb_rdata <= rsp_rd[n.slot];
        rb_status <= rsp_st[n.slot];
        rb_err <= rsp_err[n.slot];
        @(posedge pclk);
        rb_ack <= 1'b0;
        rb_rdata <= ~rb_rdata;
      end
    end
  end

  initial begin
    repeat (30000) @(posedge pclk);
    bad_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    tally_and_finish();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 32'h0; pwdata = 32'h0; stall = 3;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h20, 32'h0, r);
    check(serr, 1'b1, "unmapped refused");
    apb(1'b0, A_POST, 32'h0, r);
    check(r, 32'h0, "post register reads zero");
    $display("test register access done");
    for (int s = 0; s < 4; s++) mk(s, s[0]);
    for (int s = 0; s < 4; s++) post(s[1], s, 1'b1);
    for (int s = 0; s < 4; s++) verify(s);
    $display("test read and write mailboxes done");
    for (int s = 0; s < 4; s++) mk(s, s[1]);
    stall = 150;
    post(1'b0, 0, 1'b1);
    post(1'b0, 1, 1'b1);
    post(1'b1, 2, 1'b1);
    apb(1'b0, A_RETRIES, 32'h0, r);
    check(r[15:0], 16'h0, "other processor not locked out");
    post(1'b0, 3, 1'b0);
    apb(1'b0, A_STATUS, 32'h0, r);
    check(r[0], 1'b1, "third post of one processor pending");
    apb(1'b0, A_RETRIES, 32'h0, r);
    check(r[15:0] != 16'h0, 1'b1, "third post refused and retried");
    for (int s = 0; s < 4; s++) verify(s);
    check(exp_q.size(), 0, "all mailboxes executed");
    $display("test queue share and order done");
    tally_and_finish();
  end
endmodule
